/* include/weigh_pkg.sv */
// Purpose: Shared constants and types for the weighing indicator I/O logic.
// Assumes: 200 MHz system clock, 20-bit signed load words.
// Notes: Register offsets are byte addresses on the plain register port.
package weigh_pkg;
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int PRINT_MS = 10;
  localparam int HYST_TIME_UNIT_MS = 10;
  localparam logic [5:0] WIDTH_MS_2 = 6'h02;
  localparam logic [5:0] WIDTH_MS_5 = 6'h05;
  localparam logic [5:0] WIDTH_MS_10 = 6'h0a;
  localparam logic [5:0] WIDTH_MS_20 = 6'h14;
  localparam logic [5:0] WIDTH_MS_50 = 6'h32;
  localparam logic signed [19:0] DISP_MAX = 20'sd99999;
  localparam logic signed [19:0] DISP_MIN = -20'sd9999;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SP0 = 8'h04;
  localparam logic [7:0] OFS_HYST = 8'h18;
  localparam logic [7:0] OFS_SRC = 8'h1c;
  localparam logic [7:0] OFS_FULL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int NUM_SP = 5;
  localparam int NUM_IN = 8;
  localparam int IN_ZERO = 0;
  localparam int IN_TARE = 1;
  localparam int IN_TARE_CLR = 2;
  localparam int IN_HOLD = 3;
  localparam int IN_LOCK = 4;
  localparam int IN_SEL1 = 5;
  localparam int IN_SEL2 = 6;
  localparam int IN_OUT_DIS = 7;

  typedef enum logic [2:0] {
    SRC_FULL = 3'h0, SRC_PAIR_OFF = 3'h1, SRC_OWN = 3'h2, SRC_HOLD = 3'h3,
    SRC_PEAK = 3'h4, SRC_MEASURE = 3'h5, SRC_STABLE = 3'h6
  } zero_src_type;

  typedef enum logic [1:0] {MODE_MEASURE = 2'b00, MODE_FUNCTION = 2'b01} mode_type;

  typedef struct packed {
    logic analog_net;
    logic hold_load_if;
    logic hold_analog;
    logic hold_comp;
    logic hold_disp;
    logic [2:0] conv_rate;
    logic [1:0] disp_rate;
    logic [1:0] incr;
    logic [2:0] level_w;
    logic [2:0] pulse_w;
  } cfg_type;

  typedef struct packed {
    logic [4:0] dir_over;
    logic on_delay;
    logic [9:0] time_band;
    logic [6:0] data_band;
  } hyst_type;

  typedef struct packed {
    logic [19:0] digits;
    logic sign_line;
    logic print_cmd;
    logic overrange_flag;
    logic error;
    logic oe_n;
  } bcd_type;

  localparam cfg_type CFG_RESET = '{analog_net: 1'b0, hold_load_if: 1'b1, hold_analog: 1'b1,
    hold_comp: 1'b1, hold_disp: 1'b1, conv_rate: 3'h0, disp_rate: 2'h1, incr: 2'h0,
    level_w: 3'h4, pulse_w: 3'h4};
  localparam hyst_type HYST_RESET = '0;
endpackage

/* core/weigh_indicator_io_logic.sv */
// Purpose: Control input qualification, comparators, status and parallel decimal output.
// Assumes: Inputs synchronous to SYS_CLK; load words come from the conversion pipeline.
// Notes: CE low freezes every flip-flop.
// Notes on behaviour
// - Zero and tare pulse inputs act once after staying active the chosen width.
// - Hold and lock levels count only after staying shorted the chosen time.
// - Hold freezes each output that is chosen as a hold target.
// - Key-lock makes the front keys ignored.
// - Display spans -9999 to 99999, with under and over indications beyond.
// - Displayed value is quantised to steps of 1, 2, 5 or 10.
// - Display refreshes 4, 20, 50 or 100 times per second, default 20.
// - Conversions arrive 10, 20, 50, 100 or 200 per second, default 200.
// - Five signed setpoints from -99999 to 99999; setpoint zero role is configurable.
// - Comparators have a 0-99 count band and a 0-9.99 s on or off delay.
// - Comparators are evaluated at the conversion rate.
// - Setpoint one to four outputs turn on above or below their setpoints.
// - Setpoint zero output comes from one of seven configured sources.
// - Run output is on in measurement mode only.
// - Error output is on while any error condition exists.
// - Five decimal digits plus a sign line that is on for negative values.
// - Print command turns on at each decimal update and off a fixed time after the last one.
// - Two select inputs choose gross, tare portion or displayed value.
// - Output-disable sets oe_n high so all decimal outputs are undriven; digits, sign and print go on updating.
// - Configuration picks which of display, analog, load interface and comparators the hold input freezes.
// - Analog output follows gross or net weight as configured.
// - Function key toggles between measurement and function mode; with shift it toggles span check.
// - Over-range or error shows its flag and blanks digits, print and sign.
// - Print command stays off while hold is asserted.
`timescale 1ns/1ps
module weigh_indicator_io_logic
  import weigh_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic ZERO_IN,
  input wire logic TARE_IN,
  input wire logic TARE_CLR_IN,
  input wire logic HOLD_IN,
  input wire logic LOCK_IN,
  input wire logic SEL1_IN,
  input wire logic SEL2_IN,
  input wire logic OUT_DIS_IN,
  input wire logic FUNCTION_KEY,
  input wire logic SHIFT_KEY,
  input wire logic signed [19:0] GROSS_IN,
  input wire logic signed [19:0] NET_IN,
  input wire logic signed [19:0] TARE_PART_IN,
  input wire logic PEAK_IN,
  input wire logic STABLE_IN,
  input wire logic [7:0] ERR_IN,
  output logic ZERO_CMD,
  output logic TARE_CMD,
  output logic TARE_CLR_CMD,
  output logic signed [19:0] DISP_VALUE,
  output logic OVERLOAD_INDICATION,
  output logic UNDERLOAD_INDICATION,
  output logic SETPOINT_ZERO,
  output logic SETPOINT_ONE,
  output logic SETPOINT_TWO,
  output logic SETPOINT_THREE,
  output logic SETPOINT_FOUR,
  output logic RUN_OUT,
  output logic ERROR_OUT,
  output logic HOLD_INDICATOR,
  output logic SPAN_CHECK,
  output logic signed [19:0] ANALOG_VALUE,
  output logic signed [19:0] LOAD_IF_VALUE,
  output bcd_type BCD_OUT
);
  localparam logic [23:0] MS_CYC = 24'(MS_CYCLES_P);

  cfg_type cfg_q;
  hyst_type hyst_q;
  logic [2:0] zsrc_q;
  logic [3:0] pair_q;
  logic signed [19:0] full_q;
  logic signed [19:0] sp_q [NUM_SP];
  logic [NUM_IN-1:0] raw, s1_q, s2_q, qual_q, qual_prev_q;
  logic [23:0] qcnt_q [NUM_IN];
  logic [23:0] ms_cnt_q;
  logic ms_tick_q;
  logic [6:0] conv_cnt_q, disp_cnt_q;
  logic [5:0] print_cnt_q;
  logic conv_tick, disp_tick;
  logic hold, lock, out_dis;
  logic signed [19:0] load_q;
  logic [NUM_SP-1:0] raw_q, cmp_q;
  logic [13:0] htime_q [NUM_SP];
  mode_type mode_q;
  logic overrange;

  function automatic logic [5:0] width_ms(input logic [2:0] sel);
    case (sel)
      3'h0: width_ms = WIDTH_MS_2;
      3'h1: width_ms = WIDTH_MS_5;
      3'h2: width_ms = WIDTH_MS_10;
      3'h3: width_ms = WIDTH_MS_20;
      default: width_ms = WIDTH_MS_50;
    endcase
  endfunction

  function automatic logic [19:0] to_bcd(input logic [16:0] bin);
    logic [19:0] bcd;
    bcd = '0;
    for (int i = 16; i >= 0; i--) begin
      for (int d = 0; d < 5; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[18:0], bin[i]};
    end
    to_bcd = bcd;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      cfg_q <= CFG_RESET;
      hyst_q <= HYST_RESET;
      zsrc_q <= SRC_OWN;
      pair_q <= 4'h1;
      full_q <= DISP_MAX;
      for (int i = 0; i < NUM_SP; i++) begin
        sp_q[i] <= '0;
      end
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        OFS_CONFIG: cfg_q <= cfg_type'(REG_WDATA[$bits(cfg_type)-1:0]);
        OFS_HYST: hyst_q <= hyst_type'(REG_WDATA[$bits(hyst_type)-1:0]);
        OFS_SRC: begin
          zsrc_q <= REG_WDATA[2:0];
          pair_q <= REG_WDATA[7:4];
        end
        OFS_FULL: full_q <= REG_WDATA[19:0];
        default: begin
          for (int i = 0; i < NUM_SP; i++) begin
            if (REG_ADDR == OFS_SP0 + 8'(4 * i)) begin
              sp_q[i] <= REG_WDATA[19:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      REG_RDATA <= '0;
    end else if (CE) begin
      REG_RDATA <= '0;
      if (REG_RD) begin
        case (REG_ADDR)
          OFS_CONFIG: REG_RDATA <= 32'(cfg_q);
          OFS_HYST: REG_RDATA <= 32'(hyst_q);
          OFS_SRC: REG_RDATA <= {24'h0, pair_q, 1'b0, zsrc_q};
          OFS_FULL: REG_RDATA <= {{12{full_q[19]}}, full_q};
          OFS_STATUS: REG_RDATA <= {18'h0, raw_q, cmp_q, SPAN_CHECK, mode_q[0], qual_q[IN_LOCK],
            qual_q[IN_HOLD]};
          default: begin
            for (int i = 0; i < NUM_SP; i++) begin
              if (REG_ADDR == OFS_SP0 + 8'(4 * i)) begin
                REG_RDATA <= {{12{sp_q[i][19]}}, sp_q[i]};
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and width qualification
  assign raw = {OUT_DIS_IN, SEL2_IN, SEL1_IN, LOCK_IN, HOLD_IN, TARE_CLR_IN, TARE_IN, ZERO_IN};

  for (genvar g = 0; g < NUM_IN; g++) begin : g_qual
    logic [23:0] limit;
    assign limit = (g <= IN_TARE_CLR) ? 24'(width_ms(cfg_q.pulse_w)) * MS_CYC
                                      : 24'(width_ms(cfg_q.level_w)) * MS_CYC;
    always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        qcnt_q[g] <= '0;
        qual_q[g] <= 1'b0;
        qual_prev_q[g] <= 1'b0;
      end else if (CE) begin
        s1_q[g] <= raw[g];
        s2_q[g] <= s1_q[g];
        qual_prev_q[g] <= qual_q[g];
        if (!s2_q[g]) begin
          qcnt_q[g] <= '0;
          qual_q[g] <= 1'b0;
        end else if (qcnt_q[g] < limit) begin
          qcnt_q[g] <= qcnt_q[g] + 24'h1;
        end else begin
          qual_q[g] <= 1'b1;
        end
      end
    end
  end

  assign hold = qual_q[IN_HOLD];
  assign lock = qual_q[IN_LOCK];
  assign out_dis = qual_q[IN_OUT_DIS];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ZERO_CMD <= 1'b0;
      TARE_CMD <= 1'b0;
      TARE_CLR_CMD <= 1'b0;
      HOLD_INDICATOR <= 1'b0;
    end else if (CE) begin
      ZERO_CMD <= qual_q[IN_ZERO] && !qual_prev_q[IN_ZERO];
      TARE_CMD <= qual_q[IN_TARE] && !qual_prev_q[IN_TARE];
      TARE_CLR_CMD <= qual_q[IN_TARE_CLR] && !qual_prev_q[IN_TARE_CLR];
      HOLD_INDICATOR <= hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate generators: 1 ms base, conversion and display periods in ms
  logic [6:0] conv_per, disp_per;
  always_comb begin
    case (cfg_q.conv_rate)
      3'h0: conv_per = 7'd5;
      3'h1: conv_per = 7'd10;
      3'h2: conv_per = 7'd20;
      3'h3: conv_per = 7'd50;
      default: conv_per = 7'd100;
    endcase
    case (cfg_q.disp_rate)
      2'h0: disp_per = 7'd10;
      2'h1: disp_per = 7'd50;
      2'h2: disp_per = 7'd20;
      default: disp_per = 7'd125;
    endcase
  end
  // The 4/s rate uses 2 x 125 ms; the extra stage keeps counters at 7 bits
  logic disp_half_q;
  assign conv_tick = ms_tick_q && (conv_cnt_q == conv_per - 7'd1);
  assign disp_tick = ms_tick_q && (disp_cnt_q == disp_per - 7'd1)
                     && (cfg_q.disp_rate != 2'h3 || disp_half_q);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
      conv_cnt_q <= '0;
      disp_cnt_q <= '0;
      disp_half_q <= 1'b0;
    end else if (CE) begin
      ms_tick_q <= (ms_cnt_q == MS_CYC - 24'h1);
      ms_cnt_q <= (ms_cnt_q == MS_CYC - 24'h1) ? '0 : ms_cnt_q + 24'h1;
      if (ms_tick_q) begin
        conv_cnt_q <= (conv_cnt_q >= conv_per - 7'd1) ? '0 : conv_cnt_q + 7'd1;
        if (disp_cnt_q >= disp_per - 7'd1) begin
          disp_cnt_q <= '0;
          disp_half_q <= !disp_half_q;
        end else begin
          disp_cnt_q <= disp_cnt_q + 7'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display, analog and load interface values
  logic signed [19:0] quant;
  logic signed [19:0] step;
  always_comb begin
    case (cfg_q.incr)
      2'h0: step = 20'sd1;
      2'h1: step = 20'sd2;
      2'h2: step = 20'sd5;
      default: step = 20'sd10;
    endcase
    quant = NET_IN - (NET_IN % step);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      DISP_VALUE <= '0;
      OVERLOAD_INDICATION <= 1'b0;
      UNDERLOAD_INDICATION <= 1'b0;
    end else if (CE && disp_tick && !(hold && cfg_q.hold_disp)) begin
      DISP_VALUE <= quant;
      OVERLOAD_INDICATION <= NET_IN > DISP_MAX;
      UNDERLOAD_INDICATION <= NET_IN < DISP_MIN;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ANALOG_VALUE <= '0;
      LOAD_IF_VALUE <= '0;
      load_q <= '0;
    end else if (CE && conv_tick) begin
      if (!(hold && cfg_q.hold_analog)) begin
        ANALOG_VALUE <= cfg_q.analog_net ? NET_IN : GROSS_IN;
      end
      if (!(hold && cfg_q.hold_load_if)) begin
        LOAD_IF_VALUE <= NET_IN;
      end
      load_q <= NET_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators with data band and timed band
  logic comp_freeze;
  assign comp_freeze = hold && cfg_q.hold_comp;
  for (genvar c = 0; c < NUM_SP; c++) begin : g_cmp
    logic signed [19:0] band;
    logic hit;
    assign band = 20'(hyst_q.data_band);
    always_comb begin
      if (hyst_q.dir_over[c]) begin
        hit = raw_q[c] ? (load_q >= sp_q[c] - band) : (load_q >= sp_q[c]);
      end else begin
        hit = raw_q[c] ? (load_q <= sp_q[c] + band) : (load_q <= sp_q[c]);
      end
    end
    always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
        raw_q[c] <= 1'b0;
        cmp_q[c] <= 1'b0;
        htime_q[c] <= '0;
      end else if (CE && !comp_freeze) begin
        if (conv_tick) begin
          raw_q[c] <= hit;
        end
        if (raw_q[c] == cmp_q[c] || (raw_q[c] != hyst_q.on_delay)) begin
          htime_q[c] <= '0;
          if (raw_q[c] != cmp_q[c]) begin
            cmp_q[c] <= raw_q[c];
          end
        end else if (htime_q[c] >= 14'(hyst_q.time_band) * 14'(HYST_TIME_UNIT_MS)) begin
          cmp_q[c] <= raw_q[c];
          htime_q[c] <= '0;
        end else if (ms_tick_q) begin
          htime_q[c] <= htime_q[c] + 14'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-collector style status outputs and function mode
  logic zero_sel;
  always_comb begin
    case (zsrc_q)
      SRC_FULL: zero_sel = load_q >= full_q;
      SRC_PAIR_OFF: zero_sel = !cmp_q[{1'b0, pair_q[1:0]} + 3'h1]
                               && !cmp_q[{1'b0, pair_q[3:2]} + 3'h1];
      SRC_OWN: zero_sel = cmp_q[0];
      SRC_HOLD: zero_sel = hold;
      SRC_PEAK: zero_sel = PEAK_IN;
      SRC_MEASURE: zero_sel = mode_q == MODE_MEASURE;
      SRC_STABLE: zero_sel = STABLE_IN;
      default: zero_sel = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      {SETPOINT_ZERO, SETPOINT_ONE, SETPOINT_TWO, SETPOINT_THREE, SETPOINT_FOUR} <= '0;
      ERROR_OUT <= 1'b0;
      RUN_OUT <= 1'b0;
    end else if (CE) begin
      SETPOINT_ZERO <= zero_sel;
      {SETPOINT_FOUR, SETPOINT_THREE, SETPOINT_TWO, SETPOINT_ONE} <= cmp_q[4:1];
      ERROR_OUT <= |ERR_IN;
      RUN_OUT <= mode_q == MODE_MEASURE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      mode_q <= MODE_MEASURE;
      SPAN_CHECK <= 1'b0;
    end else if (CE && FUNCTION_KEY && !lock) begin
      if (SHIFT_KEY) begin
        SPAN_CHECK <= !SPAN_CHECK;
      end else begin
        mode_q <= (mode_q == MODE_MEASURE) ? MODE_FUNCTION : MODE_MEASURE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel decimal output
  logic signed [19:0] bcd_src;
  logic [19:0] mag;
  always_comb begin
    case ({qual_q[IN_SEL2], qual_q[IN_SEL1]})
      2'b01: bcd_src = TARE_PART_IN;
      2'b10: bcd_src = DISP_VALUE;
      default: bcd_src = GROSS_IN;
    endcase
    mag = bcd_src[19] ? 20'(-bcd_src) : bcd_src;
  end
  assign overrange = bcd_src > DISP_MAX || bcd_src < -DISP_MAX;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      BCD_OUT <= '{digits: '0, sign_line: 1'b0, print_cmd: 1'b0, overrange_flag: 1'b0,
                   error: 1'b0, oe_n: 1'b1};
      print_cnt_q <= '0;
    end else if (CE) begin
      BCD_OUT.oe_n <= out_dis;
      if (hold) begin
        BCD_OUT.print_cmd <= 1'b0;
        print_cnt_q <= '0;
      end else if (conv_tick) begin
        BCD_OUT.overrange_flag <= overrange;
        BCD_OUT.error <= |ERR_IN;
        if (overrange || |ERR_IN) begin
          BCD_OUT.digits <= '0;
          BCD_OUT.sign_line <= 1'b0;
          BCD_OUT.print_cmd <= 1'b0;
          print_cnt_q <= '0;
        end else begin
          BCD_OUT.digits <= to_bcd(mag[16:0]);
          BCD_OUT.sign_line <= bcd_src[19];
          BCD_OUT.print_cmd <= 1'b1;
          print_cnt_q <= 6'(PRINT_MS);
        end
      end else if (ms_tick_q && print_cnt_q != '0) begin
        print_cnt_q <= print_cnt_q - 6'h1;
        if (print_cnt_q == 6'h1) begin
          BCD_OUT.print_cmd <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pc_off_hold:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B) (CE && hold) |=> !BCD_OUT.print_cmd)
    else $error("print command high during hold");
  a_ovr_blanks:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    BCD_OUT.overrange_flag |-> (BCD_OUT.digits == '0 && !BCD_OUT.sign_line && !BCD_OUT.print_cmd))
    else $error("digits not blanked on over-range");
  a_disable_hiz:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B) (CE && out_dis) |=> BCD_OUT.oe_n)
    else $error("decimal outputs driven while disabled");
  a_lock_keys:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CE && lock) |=> ($stable(mode_q) && $stable(SPAN_CHECK)))
    else $error("key acted while locked");
  a_function_key_toggle:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CE && FUNCTION_KEY && !SHIFT_KEY && !lock) ##1 CE |=> RUN_OUT != $past(RUN_OUT, 2))
    else $error("run output did not follow mode change");
  a_error_out:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B) (CE && ERR_IN != 8'h0) |=> ERROR_OUT)
    else $error("error output missing");
  a_zero_once:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B) (CE && ZERO_CMD) |=> !ZERO_CMD)
    else $error("zero command longer than one cycle");
  a_over_display:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (CE && disp_tick && !(hold && cfg_q.hold_disp) && NET_IN > DISP_MAX) |=> OVERLOAD_INDICATION)
    else $error("overload indication missing");
  a_pc_length:
  assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $rose(BCD_OUT.print_cmd) |-> print_cnt_q == 6'(PRINT_MS))
    else $error("print command started without its timer");
endmodule

/* dv/plc_model.sv */
// Purpose: Controller model on the control input lines.
// Assumes: Line high while shorted; changed just after a rising edge.
// Notes: Lines are only ever driven to a firm 0 or 1.
`timescale 1ns/1ps
module plc_model (
  input wire logic clk,
  output logic [7:0] lines
);
  initial lines = '0;
  // Short for a whole number of cycles, then open
  task automatic short_for(input int idx, input int cyc);
    @(posedge clk);
    lines[idx] <= 1'b1;
    repeat (cyc) @(posedge clk);
    lines[idx] <= 1'b0;
  endtask
  task automatic set_level(input int idx, input logic v);
    @(posedge clk);
    lines[idx] <= v;
  endtask
endmodule

/* dv/weigh_indicator_io_logic_test.sv */
// Purpose: Self-checking bench for the indicator I/O logic.
// Assumes: MS_CYCLES_P of 20, so 1 ms is 20 cycles and a 200/s tick is 100.
// Notes: CE is tied high; widths are cut to 2 ms to keep the run short.
`timescale 1ns/1ps
module weigh_indicator_io_logic_test;
  import weigh_pkg::*;
  localparam int MSC = 20;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, fkey = 0, skey = 0;
  logic [7:0] addr = '0, err = '0;
  logic [31:0] wdata = '0, rdata;
  logic signed [19:0] gross = '0;
  logic [7:0] lines;
  logic zcmd, sp0, sp1, run, erro, holdi, span;
  bcd_type bcd;
  int n_fail = 0, compares = 0, n_zero = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (zcmd === 1'b1) n_zero <= n_zero + 1;
  plc_model i_plc_model (.clk(clk), .lines(lines));
  weigh_indicator_io_logic #(.MS_CYCLES_P(MSC)) i_weigh_indicator_io_logic (
    .SYS_CLK(clk), .RST_B(rst_b), .CE(1'b1), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ZERO_IN(lines[IN_ZERO]),
    .TARE_IN(lines[IN_TARE]), .TARE_CLR_IN(lines[IN_TARE_CLR]),
    .HOLD_IN(lines[IN_HOLD]), .LOCK_IN(lines[IN_LOCK]), .SEL1_IN(lines[IN_SEL1]),
    .SEL2_IN(lines[IN_SEL2]), .OUT_DIS_IN(lines[IN_OUT_DIS]), .FUNCTION_KEY(fkey),
    .SHIFT_KEY(skey), .GROSS_IN(gross), .NET_IN(gross), .TARE_PART_IN(-gross),
    .PEAK_IN(1'b0), .STABLE_IN(1'b0), .ERR_IN(err), .ZERO_CMD(zcmd), .TARE_CMD(),
    .TARE_CLR_CMD(), .DISP_VALUE(), .OVERLOAD_INDICATION(), .UNDERLOAD_INDICATION(),
    .SETPOINT_ZERO(sp0), .SETPOINT_ONE(sp1), .SETPOINT_TWO(), .SETPOINT_THREE(),
    .SETPOINT_FOUR(), .RUN_OUT(run), .ERROR_OUT(erro), .HOLD_INDICATOR(holdi),
    .SPAN_CHECK(span), .ANALOG_VALUE(), .LOAD_IF_VALUE(), .BCD_OUT(bcd));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic press(input logic sh);
    @(posedge clk);
    fkey <= 1'b1;
    skey <= sh;
    @(posedge clk);
    fkey <= 1'b0;
    skey <= 1'b0;
    cyc(4);
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    cfg_type c;
    reg_rd(OFS_CONFIG, d);
    chk("config", d, 32'(CFG_RESET));
    chk("oe_n", 32'(bcd.oe_n), 32'h0);
    chk("run", 32'(run), 32'h1);
    reg_rd(8'h40, d);
    chk("unmapped", d, 32'h0);
    c = CFG_RESET;
    c.pulse_w = 3'h0;
    c.level_w = 3'h0;
    reg_wr(OFS_CONFIG, 32'(c));
  endtask
  task automatic t_pulse;
    // 2 ms is 40 cycles; a pulse of half that must never act
    i_plc_model.short_for(IN_ZERO, 20);
    cyc(60);
    chk("short pulse", n_zero, 0);
    i_plc_model.short_for(IN_ZERO, 200);
    cyc(20);
    chk("long pulse", n_zero, 1);
  endtask
  task automatic t_setpoint;
    logic [31:0] d;
    reg_wr(OFS_SP0 + 8'h04, 32'hffff_fffb);
    reg_rd(OFS_SP0 + 8'h04, d);
    chk("sp1 readback", d, 32'hffff_fffb);
    reg_wr(OFS_SP0 + 8'h04, 32'd100);
    reg_wr(OFS_HYST, 32'h0008_0000);
    gross <= 20'sd200;
    cyc(250);
    chk("sp1 over", 32'(sp1), 32'h1);
    gross <= 20'sd50;
    cyc(250);
    chk("sp1 under", 32'(sp1), 32'h0);
  endtask
  task automatic t_decimal;
    gross <= -20'sd123;
    cyc(250);
    chk("digits", 32'(bcd.digits), 32'h00123);
    chk("sign", 32'(bcd.sign_line), 32'h1);
    chk("sp0 under", 32'(sp0), 32'h1);
    i_plc_model.set_level(IN_HOLD, 1'b1);
    cyc(60);
    chk("hold ind", 32'(holdi), 32'h1);
    gross <= 20'sd456;
    cyc(250);
    chk("held digits", 32'(bcd.digits), 32'h00123);
    chk("held print", 32'(bcd.print_cmd), 32'h0);
    i_plc_model.set_level(IN_HOLD, 1'b0);
    cyc(250);
    chk("new digits", 32'(bcd.digits), 32'h00456);
    chk("plus sign", 32'(bcd.sign_line), 32'h0);
    chk("print", 32'(bcd.print_cmd), 32'h1);
  endtask
  task automatic t_error;
    err <= 8'h04;
    cyc(250);
    chk("error out", 32'(erro), 32'h1);
    chk("error flag", 32'(bcd.error), 32'h1);
    chk("blank digits", 32'(bcd.digits), 32'h0);
    err <= 8'h00;
    i_plc_model.set_level(IN_OUT_DIS, 1'b1);
    cyc(60);
    chk("disabled", 32'(bcd.oe_n), 32'h1);
    i_plc_model.set_level(IN_OUT_DIS, 1'b0);
    cyc(60);
    chk("enabled", 32'(bcd.oe_n), 32'h0);
  endtask
  task automatic t_keys;
    press(1'b1);
    chk("span", 32'(span), 32'h1);
    press(1'b0);
    chk("function_key mode", 32'(run), 32'h0);
    press(1'b0);
    chk("measure", 32'(run), 32'h1);
    i_plc_model.set_level(IN_LOCK, 1'b1);
    cyc(60);
    press(1'b1);
    chk("locked", 32'(span), 32'h1);
    i_plc_model.set_level(IN_LOCK, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    t_reset();
    t_pulse();
    t_setpoint();
    t_decimal();
    t_error();
    t_keys();
    report_and_stop();
  end
  // Run needs about 2100 cycles; 40000 leaves ample slack
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
